//--- common/fcci_pkg.sv
// Constants and types shared by the compare and coprocessor issue block
package fcci_pkg;
  localparam int INSTR_W = 32;
  localparam int OPND_W = 128;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 30;
  localparam int MAJ_HI = 24;
  localparam int MAJ_LO = 19;
  localparam int BR2_HI = 24;
  localparam int BR2_LO = 22;
  localparam int DST_HI = 29;
  localparam int DST_LO = 25;
  localparam int SR1_HI = 18;
  localparam int SR1_LO = 14;
  localparam int SUB_HI = 13;
  localparam int SUB_LO = 5;
  localparam int SR2_HI = 4;
  localparam int SR2_LO = 0;
  localparam int SIG_BIT = 2;
  localparam logic [1:0] OPC_ARITH = 2'h2;
  localparam logic [1:0] OPC_BRANCH = 2'h0;
  localparam logic [5:0] MAJ_FGRP2 = 6'h35;
  localparam logic [5:0] MAJ_COP_A = 6'h36;
  localparam logic [5:0] MAJ_COP_B = 6'h37;
  localparam logic [8:0] SUB_CMP_S = 9'h051;
  localparam logic [8:0] SUB_CMP_D = 9'h052;
  localparam logic [8:0] SUB_CMP_Q = 9'h053;
  localparam logic [8:0] SUB_CMPS_S = 9'h055;
  localparam logic [8:0] SUB_CMPS_D = 9'h056;
  localparam logic [8:0] SUB_CMPS_Q = 9'h057;
  localparam logic [1:0] FCC_EQ = 2'h0;
  localparam logic [1:0] FCC_LT = 2'h1;
  localparam logic [1:0] FCC_GT = 2'h2;
  localparam logic [1:0] FCC_UN = 2'h3;
  localparam logic [1:0] FCC_RESET = 2'h0;
  localparam int PSW_COP_EN = 13;
  localparam int PSW_FLT_EN = 12;
  localparam int FSW_FCC_HI = 11;
  localparam int FSW_FCC_LO = 10;
  localparam logic [31:0] PSW_RESET = 32'h0;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_PSW = 4'h0;
  localparam logic [3:0] REG_FSW = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_MASK = 4'hc;
  localparam int EV_W = 7;
  localparam int EV_CMP = 0;
  localparam int EV_NV = 1;
  localparam int EV_BADREG = 2;
  localparam int EV_FOFF = 3;
  localparam int EV_COFF = 4;
  localparam int EV_CFAULT = 5;
  localparam int EV_HAZARD = 6;
  localparam int EXPW_S = 8;
  localparam int EXPW_D = 11;
  localparam int EXPW_Q = 15;
  localparam int MAGSH_S = 96;
  localparam int MAGSH_D = 64;
  localparam int MAGSH_Q = 0;

  typedef enum logic [1:0] {
    FCCI_PREC_S = 2'b01,
    FCCI_PREC_D = 2'b10,
    FCCI_PREC_Q = 2'b11
  } fcci_prec_t;

  typedef struct packed {
    logic [1:0] flags;
    logic anyNan;
    logic sigNan;
  } fcci_cmp_res_t;

  typedef struct packed {
    logic [4:0] dest;
    logic [4:0] src1;
    logic [8:0] sub;
    logic [4:0] src2;
    logic mayCc;
  } fcci_cop_req_t;

  typedef struct packed {
    logic floatOff;
    logic floatFault;
    logic illegalOp;
    logic badReg;
    logic copOff;
    logic copFault;
  } fcci_trap_t;
endpackage : fcci_pkg

//--- src/fcci_cmp_unit.sv
// Registered float comparator for single, double and quad operands
module fcci_cmp_unit #(
  parameter int OPND_W = 128
) (
  input wire logic clock,
  input wire logic reset,
  input wire fcci_pkg::fcci_prec_t prec,
  input wire logic [OPND_W-1:0] opndA,
  input wire logic [OPND_W-1:0] opndB,
  output fcci_pkg::fcci_cmp_res_t res
);
  localparam int MAG_W = OPND_W - 1;
  localparam logic [MAG_W-1:0] MAG_ONES = '1;

  if (OPND_W != fcci_pkg::OPND_W) begin : gBadWidth
    $error("Operand width must hold one quad value");
  end

  int expW;
  int magSh;
  logic [MAG_W-1:0] magMask, expMask, fracMask, magA, magB;
  logic nanA, nanB, qA, qB, sA, sB;
  fcci_pkg::fcci_cmp_res_t res_d, res_q;

  always_comb begin
    case (prec)
      fcci_pkg::FCCI_PREC_D: begin
        expW = fcci_pkg::EXPW_D;
        magSh = fcci_pkg::MAGSH_D;
      end
      fcci_pkg::FCCI_PREC_Q: begin
        expW = fcci_pkg::EXPW_Q;
        magSh = fcci_pkg::MAGSH_Q;
      end
      default: begin
        expW = fcci_pkg::EXPW_S;
        magSh = fcci_pkg::MAGSH_S;
      end
    endcase
    magMask = MAG_ONES << magSh;
    expMask = MAG_ONES << (MAG_W - expW);
    fracMask = magMask & ~expMask;
    magA = opndA[MAG_W-1:0] & magMask;
    magB = opndB[MAG_W-1:0] & magMask;
    sA = opndA[MAG_W];
    sB = opndB[MAG_W];
    qA = opndA[MAG_W-1-expW];
    qB = opndB[MAG_W-1-expW];
    nanA = ((magA & expMask) == expMask) && ((magA & fracMask) != '0);
    nanB = ((magB & expMask) == expMask) && ((magB & fracMask) != '0);
    res_d.anyNan = nanA || nanB;
    res_d.sigNan = (nanA && !qA) || (nanB && !qB);
    // Zeros of either sign are equal; otherwise order by sign, then magnitude
    if (res_d.anyNan) begin
      res_d.flags = fcci_pkg::FCC_UN;
    end else if ((magA == magB && sA == sB) || (magA == '0 && magB == '0)) begin
      res_d.flags = fcci_pkg::FCC_EQ;
    end else if (sA != sB) begin
      res_d.flags = sA ? fcci_pkg::FCC_LT : fcci_pkg::FCC_GT;
    end else if ((magA < magB) != sA) begin
      res_d.flags = fcci_pkg::FCC_LT;
    end else begin
      res_d.flags = fcci_pkg::FCC_GT;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  assign res = res_q;
endmodule : fcci_cmp_unit

//--- src/fcci_issue.sv
// Decode and issue of float compares and coprocessor operate instructions
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
module fcci_issue #(
  parameter logic [2:0] BRANCH_OP2 = 3'h6
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic instrValid,
  input wire logic [fcci_pkg::INSTR_W-1:0] instr,
  input wire logic floatHere,
  input wire logic copHere,
  input wire logic [fcci_pkg::OPND_W-1:0] opndA,
  input wire logic [fcci_pkg::OPND_W-1:0] opndB,
  input wire logic copFaultIn,
  input wire logic [fcci_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic [4:0] fRegSelA,
  output logic [4:0] fRegSelB,
  output logic [1:0] fccOut,
  output logic copIssue,
  output fcci_pkg::fcci_cop_req_t copReq,
  output fcci_pkg::fcci_trap_t traps,
  output logic irq
);
  // Instruction decode
  logic [1:0] opc;
  logic [5:0] maj;
  logic [8:0] sub;
  logic [4:0] src1, src2;
  logic isG2, isCmp, isSig, isCop, isCopB, isBr, misAl, fltOn, copOn;
  fcci_pkg::fcci_prec_t prec;
  logic [31:0] psw_q, psw_d;

  always_comb begin
    opc = instr[fcci_pkg::OPC_HI:fcci_pkg::OPC_LO];
    maj = instr[fcci_pkg::MAJ_HI:fcci_pkg::MAJ_LO];
    sub = instr[fcci_pkg::SUB_HI:fcci_pkg::SUB_LO];
    src1 = instr[fcci_pkg::SR1_HI:fcci_pkg::SR1_LO];
    src2 = instr[fcci_pkg::SR2_HI:fcci_pkg::SR2_LO];
    prec = fcci_pkg::fcci_prec_t'(sub[1:0]);
    isG2 = opc == fcci_pkg::OPC_ARITH && maj == fcci_pkg::MAJ_FGRP2;
    isCmp = isG2 && sub inside {fcci_pkg::SUB_CMP_S, fcci_pkg::SUB_CMP_D,
      fcci_pkg::SUB_CMP_Q, fcci_pkg::SUB_CMPS_S, fcci_pkg::SUB_CMPS_D,
      fcci_pkg::SUB_CMPS_Q};
    isSig = sub[fcci_pkg::SIG_BIT];
    // Only the arithmetic format counts, so loads and stores never match
    isCop = opc == fcci_pkg::OPC_ARITH &&
      (maj == fcci_pkg::MAJ_COP_A || maj == fcci_pkg::MAJ_COP_B);
    isCopB = maj == fcci_pkg::MAJ_COP_B;
    isBr = opc == fcci_pkg::OPC_BRANCH &&
      instr[fcci_pkg::BR2_HI:fcci_pkg::BR2_LO] == BRANCH_OP2;
    // Wide forms need aligned register numbers; single never faults here
    case (prec)
      fcci_pkg::FCCI_PREC_D: misAl = src1[0] || src2[0];
      fcci_pkg::FCCI_PREC_Q: misAl = (src1[1:0] != 2'h0) || (src2[1:0] != 2'h0);
      default: misAl = 1'b0;
    endcase
    fltOn = psw_q[fcci_pkg::PSW_FLT_EN] && floatHere;
    copOn = psw_q[fcci_pkg::PSW_COP_EN] && copHere;
  end

  // Source selects; the destination field goes only to the coprocessor request
  assign fRegSelA = src1;
  assign fRegSelB = src2;

  fcci_pkg::fcci_cmp_res_t cmpRes;

  fcci_cmp_unit #(
    .OPND_W(fcci_pkg::OPND_W)
  ) uCmp (
    .clock(clock),
    .reset(reset),
    .prec(prec),
    .opndA(opndA),
    .opndB(opndB),
    .res(cmpRes)
  );

  // Issue stage
  logic s1Cmp_q, s1Cmp_d, s1Sig_q, s1Sig_d, s1FOff_q, s1FOff_d, s1Bad_q, s1Bad_d;
  logic copIssue_q, copIssue_d, lastG2_q, lastG2_d;
  fcci_pkg::fcci_cop_req_t copReq_q, copReq_d;

  always_comb begin
    s1Cmp_d = instrValid && isCmp;
    s1Sig_d = isSig;
    s1FOff_d = !fltOn;
    s1Bad_d = misAl;
    copIssue_d = instrValid && isCop && copOn;
    copReq_d = copReq_q;
    if (instrValid && isCop) begin
      copReq_d.dest = instr[fcci_pkg::DST_HI:fcci_pkg::DST_LO];
      copReq_d.src1 = src1;
      copReq_d.sub = sub;
      copReq_d.src2 = src2;
      copReq_d.mayCc = isCopB;
    end
    lastG2_d = instrValid ? isG2 : lastG2_q;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s1Cmp_q <= 1'b0;
      s1Sig_q <= 1'b0;
      s1FOff_q <= 1'b0;
      s1Bad_q <= 1'b0;
      copIssue_q <= 1'b0;
      copReq_q <= '0;
      lastG2_q <= 1'b0;
    end else begin
      s1Cmp_q <= s1Cmp_d;
      s1Sig_q <= s1Sig_d;
      s1FOff_q <= s1FOff_d;
      s1Bad_q <= s1Bad_d;
      copIssue_q <= copIssue_d;
      copReq_q <= copReq_d;
      lastG2_q <= lastG2_d;
    end
  end

  assign copIssue = copIssue_q;
  assign copReq = copReq_q;

  // Result stage: flags and traps
  logic nvFault, cmpOk, fswWr;
  logic [1:0] fcc_q, fcc_d;
  fcci_pkg::fcci_trap_t trap_q, trap_d;
  logic [fcci_pkg::EV_W-1:0] ev;

  always_comb begin
    fswWr = regWr && regAddr == fcci_pkg::REG_FSW;
    nvFault = s1Sig_q ? cmpRes.anyNan : cmpRes.sigNan;
    cmpOk = s1Cmp_q && !s1FOff_q && !s1Bad_q;
    trap_d.floatOff = s1Cmp_q && s1FOff_q;
    trap_d.badReg = s1Cmp_q && !s1FOff_q && s1Bad_q;
    trap_d.illegalOp = cmpOk && nvFault;
    trap_d.floatFault = trap_d.badReg || trap_d.illegalOp;
    trap_d.copOff = instrValid && isCop && !copOn;
    trap_d.copFault = copFaultIn;
    fcc_d = fcc_q;
    if (fswWr) begin
      fcc_d = regWrData[fcci_pkg::FSW_FCC_HI:fcci_pkg::FSW_FCC_LO];
    end
    if (cmpOk && !nvFault) begin
      fcc_d = cmpRes.flags;
    end
    ev = '0;
    ev[fcci_pkg::EV_CMP] = cmpOk && !nvFault;
    ev[fcci_pkg::EV_NV] = trap_d.illegalOp;
    ev[fcci_pkg::EV_BADREG] = trap_d.badReg;
    ev[fcci_pkg::EV_FOFF] = trap_d.floatOff;
    ev[fcci_pkg::EV_COFF] = trap_d.copOff;
    ev[fcci_pkg::EV_CFAULT] = trap_d.copFault;
    ev[fcci_pkg::EV_HAZARD] = instrValid && isBr && lastG2_q;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fcc_q <= fcci_pkg::FCC_RESET;
      trap_q <= '0;
    end else begin
      fcc_q <= fcc_d;
      trap_q <= trap_d;
    end
  end

  assign fccOut = fcc_q;
  assign traps = trap_q;

  // Register port
  logic [fcci_pkg::EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rdData_q, rdData_d;

  always_comb begin
    psw_d = psw_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (regWr && regAddr == fcci_pkg::REG_PSW) begin
      psw_d = regWrData;
    end
    if (regWr && regAddr == fcci_pkg::REG_MASK) begin
      mask_d = regWrData[fcci_pkg::EV_W-1:0];
    end
    if (regWr && regAddr == fcci_pkg::REG_STAT) begin
      stat_d = stat_q & ~regWrData[fcci_pkg::EV_W-1:0];
    end
    stat_d = stat_d | ev;
    rdData_d = '0;
    if (regRd) begin
      case (regAddr)
        fcci_pkg::REG_PSW: rdData_d = psw_q;
        fcci_pkg::REG_FSW: rdData_d[fcci_pkg::FSW_FCC_HI:fcci_pkg::FSW_FCC_LO] = fcc_q;
        fcci_pkg::REG_STAT: rdData_d[fcci_pkg::EV_W-1:0] = stat_q;
        fcci_pkg::REG_MASK: rdData_d[fcci_pkg::EV_W-1:0] = mask_q;
        default: rdData_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      psw_q <= fcci_pkg::PSW_RESET;
      stat_q <= '0;
      mask_q <= '0;
      rdData_q <= '0;
    end else begin
      psw_q <= psw_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
  assign irq = (stat_q & mask_q) != '0;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  AST_FCC_SET: assert property (
    s1Cmp_q && !s1FOff_q && !s1Bad_q && !nvFault |=> fccOut == $past(cmpRes.flags))
    else $error("Flags not taken from compare result");

  AST_FCC_HOLD: assert property (!s1Cmp_q && !fswWr |=> $stable(fccOut))
    else $error("Flags changed without a compare");

  AST_SIG_NAN: assert property (
    instrValid && isCmp && isSig && fltOn && !misAl ##1 cmpRes.anyNan
    |=> traps.floatFault && traps.illegalOp)
    else $error("Signalling compare missed NaN fault");

  AST_QNAN_QUIET: assert property (
    s1Cmp_q && !s1Sig_q && !cmpRes.sigNan |-> !trap_d.illegalOp ##1 !traps.illegalOp)
    else $error("Plain compare faulted without signalling NaN");

  AST_SINGLE_NOBAD: assert property (
    instrValid && isCmp && prec == fcci_pkg::FCCI_PREC_S |-> ##2 !traps.badReg)
    else $error("Single compare gave bad register fault");

  AST_DOUBLE_BAD: assert property (
    instrValid && isCmp && fltOn && prec == fcci_pkg::FCCI_PREC_D && src1[0]
    |-> ##2 traps.floatFault && traps.badReg && $stable(fccOut))
    else $error("Odd double register not faulted");

  AST_COP_OFF: assert property (
    instrValid && isCop && !copOn |=> traps.copOff && !copIssue)
    else $error("Disabled coprocessor op not trapped");

  AST_COP_PASS: assert property (
    instrValid && isCop && copOn |=> copIssue && copReq.sub == $past(sub)
    && copReq.src1 == $past(src1) && copReq.src2 == $past(src2)
    && copReq.dest == $past(instr[fcci_pkg::DST_HI:fcci_pkg::DST_LO]))
    else $error("Coprocessor fields not passed through");

  AST_COP_A_CC: assert property (
    instrValid && isCop && !isCopB |=> !copReq.mayCc)
    else $error("Operate A allowed condition update");

  AST_COP_FAULT: assert property (
    copFaultIn |=> traps.copFault && stat_q[fcci_pkg::EV_CFAULT])
    else $error("Coprocessor fault not taken");

  AST_LDST: assert property (
    instrValid && opc != fcci_pkg::OPC_ARITH |=> !copIssue && !traps.copOff)
    else $error("Non operate format issued to coprocessor");

  AST_FSW_READ: assert property (
    regRd && regAddr == fcci_pkg::REG_FSW
    |=> regRdData[fcci_pkg::FSW_FCC_HI:fcci_pkg::FSW_FCC_LO] == $past(fccOut))
    else $error("Flags not readable in the float state word");

  AST_EN_BIT: assert property (
    instrValid && isCop && !psw_q[fcci_pkg::PSW_COP_EN] |=> traps.copOff && !copIssue)
    else $error("Coprocessor ran with its enable bit clear");

  AST_TRAP_KEEPS_FCC: assert property (
    s1Cmp_q && (s1FOff_q || s1Bad_q) && !fswWr |=> $stable(fccOut))
    else $error("Trapped compare changed the flags");

  COV_UNORD: cover property (s1Cmp_q ##1 fccOut == fcci_pkg::FCC_UN);
  COV_COP: cover property (instrValid && isCop && copOn ##1 copIssue);
  COV_HAZ: cover property (instrValid && isCmp ##1 instrValid && isBr);
  COV_IRQ: cover property (!irq ##1 irq);
endmodule : fcci_issue

//--- test/fcci_far_model.sv
// Far side model: float register file and coprocessor
module fcci_far_model (
  input wire logic clock,
  input wire logic [4:0] fRegSelA,
  input wire logic [4:0] fRegSelB,
  output logic [fcci_pkg::OPND_W-1:0] opndA,
  output logic [fcci_pkg::OPND_W-1:0] opndB,
  input wire logic ldEn,
  input wire logic [4:0] ldIdx,
  input wire logic [fcci_pkg::OPND_W-1:0] ldVal,
  input wire logic present,
  output logic copHere,
  input wire logic faultReq,
  output logic copFaultIn,
  input wire logic copIssue,
  input wire fcci_pkg::fcci_cop_req_t copReq,
  output int ccUpdates
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [fcci_pkg::OPND_W-1:0] fregs [32];
  assign opndA = fregs[fRegSelA];
  assign opndB = fregs[fRegSelB];
  assign copHere = present;
  assign copFaultIn = faultReq;
  initial ccUpdates = 0;
  always @(posedge clock) begin
    if (ldEn) begin
      fregs[ldIdx] <= ldVal;
    end
    // Fields used as own register numbers; only operate B moves condition codes
    if (copIssue && copReq.mayCc) begin
      ccUpdates <= ccUpdates + 1;
    end
  end
endmodule : fcci_far_model

//--- test/test_float_compare_coproc_issue.sv
// Self-checking bench for the compare and coprocessor issue block
module test_float_compare_coproc_issue;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset, instrValid, floatHere, copHere, copFaultIn, regWr, regRd;
  logic copIssue, irq, ldEn, present, faultReq;
  logic [31:0] instr, regWrData, regRdData;
  logic [3:0] regAddr;
  logic [4:0] fRegSelA, fRegSelB, ldIdx;
  logic [1:0] fccOut;
  logic [127:0] opndA, opndB, ldVal;
  fcci_pkg::fcci_cop_req_t copReq;
  fcci_pkg::fcci_trap_t traps;
  int ccUpdates, mismatches, comparisons;
  logic [31:0] seed = 32'hca5e120c;

  fcci_issue #(.BRANCH_OP2(3'h6)) dut (.clock, .reset, .instrValid, .instr, .floatHere,
    .copHere, .opndA, .opndB, .copFaultIn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .fRegSelA, .fRegSelB, .fccOut, .copIssue, .copReq, .traps, .irq);
  fcci_far_model far (.clock, .fRegSelA, .fRegSelB, .opndA, .opndB, .ldEn, .ldIdx,
    .ldVal, .present, .copHere, .faultReq, .copFaultIn, .copIssue, .copReq, .ccUpdates);

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Returns flags, any NaN, signalling NaN for left aligned operands
  function automatic logic [3:0] cmpm(int e, int w, logic [127:0] a, logic [127:0] b);
    logic [127:0] am, bm, fm, em, qb;
    logic na, nb, sn;
    am = {1'b0, a[126:0]} >> (128 - w);
    bm = {1'b0, b[126:0]} >> (128 - w);
    fm = (128'h1 << (w - 1 - e)) - 1;
    em = ~fm & ((128'h1 << (w - 1)) - 1);
    qb = 128'h1 << (w - 2 - e);
    na = (am & em) == em && (am & fm) != 0;
    nb = (bm & em) == em && (bm & fm) != 0;
    sn = na && (am & qb) == 0 || nb && (bm & qb) == 0;
    if (na || nb) return {3'h7, sn};
    if (am == 0 && bm == 0 || a[127] == b[127] && am == bm) return 4'h0;
    if (a[127] != b[127]) return {a[127] ? 2'h1 : 2'h2, 2'h0};
    return {((am < bm) ^ a[127]) ? 2'h1 : 2'h2, 2'h0};
  endfunction : cmpm

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] a, logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rd

  task automatic load(logic [4:0] i, logic [127:0] v);
    @(posedge clock);
    ldEn <= 1'b1;
    ldIdx <= i;
    ldVal <= v;
    @(posedge clock);
    ldEn <= 1'b0;
  endtask : load

  task automatic issue(logic [31:0] w);
    @(posedge clock);
    instrValid <= 1'b1;
    instr <= w;
    @(posedge clock);
    instrValid <= 1'b0;
  endtask : issue

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    int p, s, e, w, k, expCc;
    logic [127:0] a, b, nm, qm;
    logic [4:0] r1, r2;
    logic [3:0] m;
    logic [1:0] fcc;
    logic [31:0] float_compare, x;
    logic bad, nv, en, pres;
    {reset, instrValid, regWr, regRd, ldEn, faultReq} = 6'h20;
    {instr, regWrData, regAddr, ldIdx, ldVal} = '0;
    floatHere = 1'b1;
    present = 1'b1;
    expCc = 0;
    float_compare = {2'h2, 5'h0, fcci_pkg::MAJ_FGRP2, 5'h0, fcci_pkg::SUB_CMP_S, 5'h0};
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 chk({traps, fccOut, copIssue, irq}, 0);
    rd(fcci_pkg::REG_PSW, 0);
    wr(fcci_pkg::REG_PSW, 32'h3000);
    rd(fcci_pkg::REG_PSW, 32'h3000);
    wr(fcci_pkg::REG_MASK, 32'h7f);
    wr(4'h2, 32'hffffffff);
    rd(4'h2, 0);
    wr(fcci_pkg::REG_FSW, 32'hffffffff);
    rd(fcci_pkg::REG_FSW, 32'hc00);
    fcc = 2'h3;
    $display("test registers done");
    for (int i = 0; i < 90; i++) begin
      p = 1 + i % 3;
      s = i / 3 % 2;
      e = p == 1 ? fcci_pkg::EXPW_S : p == 2 ? fcci_pkg::EXPW_D : fcci_pkg::EXPW_Q;
      w = 32 << (p - 1);
      a = {rnd(), rnd(), rnd(), rnd()};
      b = {rnd(), rnd(), rnd(), rnd()};
      k = rnd() % 5;
      r1 = 5'(rnd());
      r2 = 5'(rnd());
      nm = ((128'h1 << e) - 1) << (127 - e);
      qm = 128'h1 << (126 - e);
      if (k == 1) b = a;
      if (k == 2) a = a | nm | qm;
      if (k == 3) b = (b | nm | (128'h1 << (128 - w))) & ~qm;
      if (k == 4) begin
        a = {a[127], 127'h0};
        b = {~a[127], 127'h0};
      end
      if (k > 1) begin
        r1 = r1 & 5'h1c;
        r2 = r2 & 5'h1c;
      end
      if (r1 == r2) b = a;
      load(r1, a);
      load(r2, b);
      m = cmpm(e, w, a, b);
      bad = p == 2 && (r1[0] | r2[0]) || p == 3 && (r1[1:0] | r2[1:0]) != 0;
      nv = s ? m[1] : m[0];
      x = {2'h2, 5'(rnd()), fcci_pkg::MAJ_FGRP2, r1, 9'h050 | 9'(s * 4 + p), r2};
      issue(x);
      chk(fRegSelA, r1);
      chk(fRegSelB, r2);
      @(posedge clock);
      if (!bad && !nv) fcc = m[3:2];
      #1 chk(traps, bad ? 6'h14 : nv ? 6'h18 : 6'h0);
      chk(fccOut, fcc);
      chk(irq, 1);
      rd(fcci_pkg::REG_FSW, {fcc, 10'h0});
      rd(fcci_pkg::REG_STAT, bad ? 4 : nv ? 2 : 1);
      wr(fcci_pkg::REG_STAT, 32'h7f);
    end
    $display("test compare done");
    load(0, 0);
    for (int j = 0; j < 2; j++) begin
      wr(fcci_pkg::REG_PSW, j ? 32'h3000 : 32'h2000);
      floatHere <= (j == 0);
      issue(float_compare);
      @(posedge clock);
      #1 chk(traps, 6'h20);
      chk(fccOut, fcc);
      rd(fcci_pkg::REG_STAT, 8);
      wr(fcci_pkg::REG_STAT, 32'h7f);
    end
    floatHere <= 1'b1;
    wr(fcci_pkg::REG_PSW, 32'h3000);
    $display("test float off done");
    for (int j = 0; j < 2; j++) begin
      // Back to back: compare, optional spacer, then float branch
      @(posedge clock);
      instrValid <= 1'b1;
      instr <= float_compare;
      if (j) begin
        @(posedge clock);
        instr <= 32'h80000000;
      end
      @(posedge clock);
      instr <= {2'h0, 5'h0, 3'h6, 22'h0};
      @(posedge clock);
      instrValid <= 1'b0;
      repeat (2) @(posedge clock);
      rd(fcci_pkg::REG_STAT, j ? 1 : 32'h41);
      wr(fcci_pkg::REG_STAT, 32'h7f);
    end
    $display("test branch hazard done");
    for (int i = 0; i < 12; i++) begin
      en = i % 3 != 1;
      pres = i % 3 != 2;
      wr(fcci_pkg::REG_PSW, en ? 32'h3000 : 32'h1000);
      present <= pres;
      x = rnd();
      x[31:30] = 2'h2;
      x[24:19] = i[0] ? fcci_pkg::MAJ_COP_B : fcci_pkg::MAJ_COP_A;
      issue(x);
      #1 chk(copReq, {x[29:25], x[18:14], x[13:5], x[4:0], i[0]});
      chk(copIssue, en && pres);
      chk(traps, (en && pres) ? 6'h0 : 6'h02);
      if (en && pres && i[0]) expCc++;
    end
    present <= 1'b1;
    wr(fcci_pkg::REG_PSW, 32'h3000);
    wr(fcci_pkg::REG_STAT, 32'h7f);
    issue({2'h3, 5'h1, fcci_pkg::MAJ_COP_A, 19'h0});
    #1 chk({copIssue, traps}, 0);
    chk(ccUpdates, expCc);
    $display("test coprocessor done");
    wr(fcci_pkg::REG_MASK, 0);
    @(posedge clock);
    faultReq <= 1'b1;
    @(posedge clock);
    faultReq <= 1'b0;
    #1 chk(traps, 6'h01);
    chk(irq, 0);
    wr(fcci_pkg::REG_MASK, 32'h20);
    #1 chk(irq, 1);
    rd(fcci_pkg::REG_STAT, 32'h20);
    wr(fcci_pkg::REG_STAT, 32'h20);
    #1 chk(irq, 0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : test_float_compare_coproc_issue
